//--- core/hr_port_pkg.sv
// Shared constants for the hardware response port unit
package hr_port_pkg;

    // Clock blocks per tile; block 0 is the tile reference clock
    localparam int NUM_CLK_BLOCKS = 6;
    localparam int CB_SEL_W       = 3;
    localparam int CB_CFG_W       = 9;
    localparam int CB_DIV_W       = 8;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_DATA    = 8'h04;
    localparam logic [7:0] OFF_COND    = 8'h08;
    localparam logic [7:0] OFF_TIME    = 8'h0c;
    localparam logic [7:0] OFF_COUNTER = 8'h10;
    localparam logic [7:0] OFF_STAMP   = 8'h14;
    localparam logic [7:0] OFF_STATUS  = 8'h18;
    localparam logic [7:0] OFF_CB_BASE = 8'h20;   // Block i config at base + 4*i

    // Control register fields
    localparam int CTRL_W          = 16;
    localparam int CTRL_ENABLE     = 0;
    localparam int CTRL_DIR_OUT    = 1;
    localparam int CTRL_OPEN_COLL  = 2;
    localparam int CTRL_TIMED      = 3;
    localparam int CTRL_COND_EN    = 4;
    localparam int CTRL_COND_NEQ   = 5;
    localparam int CTRL_STB_IN_EN  = 6;
    localparam int CTRL_STB_OUT_EN = 7;
    localparam int CTRL_CLK_SEL_LO = 8;
    localparam int CTRL_SERIAL     = 11;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Clock block config fields
    localparam int CB_SRC_PIN = 8;
    localparam logic [8:0] CB_CFG_RESET = 9'h000;

    // Status register fields
    localparam int ST_OUT_FULL  = 0;
    localparam int ST_IN_VALID  = 1;
    localparam int ST_EVENT     = 2;
    localparam int ST_LINK      = 3;
    localparam int ST_COND_MET  = 4;

    // Counter and transfer register
    localparam int CNT_W  = 16;
    localparam int XFER_W = 32;
    localparam logic [15:0] CNT_RESET = 16'h0000;

endpackage

//--- core/clock_ticks_if.sv
// Tick enables from the clock blocks to the port logic
`timescale 1ns/1ps
interface clock_ticks_if #(parameter int N = 6);
    wire [N-1:0] tick;
    modport source (output tick);
    modport sink   (input  tick);
endinterface

//--- core/pin_condition.sv
// Compare of sampled pins against a software value for conditional input
`timescale 1ns/1ps
module pin_condition #(parameter int WIDTH = 4)
(
    input  wire logic [WIDTH-1:0] sample,
    input  wire logic [WIDTH-1:0] value,
    input  wire logic             neq,
    output logic                  met
);
    assign met = neq ? (sample != value) : (sample == value);
endmodule

//--- core/clock_block.sv
// One programmable clock block producing a one-cycle tick enable
`timescale 1ns/1ps
module clock_block #(parameter int INDEX = 1)
(
    input  wire logic                              clk,
    input  wire logic                              reset_n,
    input  wire logic                              src_pin,
    input  wire logic [hr_port_pkg::CB_CFG_W-1:0]  cfg,
    clock_ticks_if.source                          ticks
);
    logic                              pin_q;
    logic                              tick_q;
    logic [hr_port_pkg::CB_DIV_W-1:0]  div_cnt;
    wire                               pin_rise;
    wire                               base_tick;
    wire                               div_done;

    // pin edge as source, else every reference cycle
    assign pin_rise  = src_pin & ~pin_q;
    assign base_tick = cfg[hr_port_pkg::CB_SRC_PIN] ? pin_rise : 1'b1;
    assign div_done  = (div_cnt >= cfg[hr_port_pkg::CB_DIV_W-1:0]);

    // Divider; a divide value of zero passes every source tick
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pin_q   <= 1'b0;
            tick_q  <= 1'b0;
            div_cnt <= '0;
        end
        else
        begin
            pin_q  <= src_pin;
            tick_q <= base_tick & div_done;
            if (base_tick)
                div_cnt <= div_done ? '0 : div_cnt + 1'b1;
        end
    end

    assign ticks.tick[INDEX] = tick_q;
endmodule

//--- core/hw_response_port.sv
// Hardware response port: pins, transfer register, counter and clock blocks
//
// Functional notes
// - Port width is a parameter; one, four, eight, sixteen or thirty-two bits.
// - One direction bit covers all pins; never mixed in and out.
// - Drives pins or samples them, optionally waiting for a pin condition.
// - Every register access completes in one cycle, no wait states.
// - Open-collector per port: zero drives low, one releases the pin.
// - Data passes through serializer plus transfer register between pins and core.
// - A 16-bit counter can time the transfer moment.
// - Counter readable anytime; a programmed counter value times one transfer.
// - Counter captured as timestamp on every transfer, readable later.
// - An enabled link sharing the pins disables the port on them.
// - Narrower port claims its shared pins; other pins stay usable.
// - Port keeps its nominal width even when pins are claimed.
// - Six clock blocks; block 0 is the reference, others divisible.
// - Clock block may take a one-bit pin as source and divide it.
// - Accepts an input strobe and generates an output strobe with data.
// - After reset the port uses clock block 0.
// - Pin events go straight to the tile as a pulse, not an interrupt.
// - Pull-downs enabled on all pins while reset is held.
`timescale 1ns/1ps
module hw_response_port #(
    parameter int WIDTH  = 4,
    parameter int ADDR_W = 8
)
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    input  wire logic [WIDTH-1:0]  pin_in,
    output logic      [WIDTH-1:0]  pin_out,
    output logic      [WIDTH-1:0]  pin_oe_n,
    output logic                   pulldown_en,
    input  wire logic              strobe_input_qualifier,
    output logic                   strobe_output_marker,
    input  wire logic              link_enable,
    input  wire logic [WIDTH-1:0]  narrower_claim,
    input  wire logic              clk_pin_in,
    output logic                   event_pulse
);
    localparam int NCB   = hr_port_pkg::NUM_CLK_BLOCKS;
    localparam int XW    = hr_port_pkg::XFER_W;
    localparam int CW    = hr_port_pkg::CNT_W;
    localparam int SLOTS = XW / WIDTH;

    // Software state
    logic [hr_port_pkg::CTRL_W-1:0]   ctrl;
    logic [WIDTH-1:0]                 cond_value;
    logic [CW-1:0]                    time_value;
    logic [hr_port_pkg::CB_CFG_W-1:0] cb_cfg [NCB];

    // Port datapath state
    logic [CW-1:0]    counter;
    logic [CW-1:0]    stamp;
    logic [XW-1:0]    xfer;
    logic             xfer_full;
    logic [XW-1:0]    shift_reg;
    logic [7:0]       slot_cnt;
    logic [WIDTH-1:0] drive_val;
    logic             event_sticky;
    logic             cond_met;

    // Next values
    logic [CW-1:0]    next_stamp;
    logic [XW-1:0]    next_xfer;
    logic             next_xfer_full;
    logic [XW-1:0]    next_shift_reg;
    logic [7:0]       next_slot_cnt;
    logic [WIDTH-1:0] next_drive_val;
    logic             next_strobe;
    logic             next_event;
    logic [31:0]      next_rdata;
    logic [WIDTH-1:0] next_pin_out;
    logic [WIDTH-1:0] next_pin_oe_n;

    clock_ticks_if #(.N(NCB)) ticks ();

    // Control fields
    wire                                port_en  = ctrl[hr_port_pkg::CTRL_ENABLE];
    wire                                dir_out  = ctrl[hr_port_pkg::CTRL_DIR_OUT];
    wire                                oc_mode  = ctrl[hr_port_pkg::CTRL_OPEN_COLL];
    wire                                timed    = ctrl[hr_port_pkg::CTRL_TIMED];
    wire                                cond_en  = ctrl[hr_port_pkg::CTRL_COND_EN];
    wire                                cond_neq = ctrl[hr_port_pkg::CTRL_COND_NEQ];
    wire                                stb_in   = ctrl[hr_port_pkg::CTRL_STB_IN_EN];
    wire                                stb_out  = ctrl[hr_port_pkg::CTRL_STB_OUT_EN];
    wire                                serial   = ctrl[hr_port_pkg::CTRL_SERIAL];
    wire [hr_port_pkg::CB_SEL_W-1:0]    clk_sel  = ctrl[hr_port_pkg::CTRL_CLK_SEL_LO +: hr_port_pkg::CB_SEL_W];

    // Register decode
    wire [ADDR_W-1:0] cb_off   = addr - ADDR_W'(hr_port_pkg::OFF_CB_BASE);
    wire              cb_hit   = (addr >= ADDR_W'(hr_port_pkg::OFF_CB_BASE)) && (cb_off[ADDR_W-1:2] < NCB)
                                 && (cb_off[1:0] == 2'b00);
    wire [2:0]        cb_idx   = cb_off[4:2];
    wire              wr_ctrl  = wr && (addr == ADDR_W'(hr_port_pkg::OFF_CTRL));
    wire              wr_data  = wr && (addr == ADDR_W'(hr_port_pkg::OFF_DATA));
    wire              wr_cond  = wr && (addr == ADDR_W'(hr_port_pkg::OFF_COND));
    wire              wr_time  = wr && (addr == ADDR_W'(hr_port_pkg::OFF_TIME));
    wire              rd_data  = rd && (addr == ADDR_W'(hr_port_pkg::OFF_DATA));
    wire              rd_stat  = rd && (addr == ADDR_W'(hr_port_pkg::OFF_STATUS));

    // six clock blocks, block 0 locked to the reference rate
    genvar gi;
    generate
        for (gi = 0; gi < NCB; gi++)
        begin : g_cb
            clock_block #(.INDEX(gi)) u_cb (
                .clk     (clk),
                .reset_n (reset_n),
                .src_pin (clk_pin_in),
                .cfg     (gi == 0 ? hr_port_pkg::CB_CFG_RESET : cb_cfg[gi]),
                .ticks   (ticks.source)
            );
        end
    endgenerate

    // select falls back to block 0 for out-of-range codes
    wire sel_tick = (clk_sel < NCB) ? ticks.tick[clk_sel] : ticks.tick[0];

    // conditional compare on the live pins
    pin_condition #(.WIDTH(WIDTH)) u_cond (
        .sample (pin_in),
        .value  (cond_value),
        .neq    (cond_neq),
        .met    (cond_met)
    );

    // a live link takes the pins away from the port
    wire port_live = port_en && !link_enable;
    // timed transfer fires only at the programmed count
    wire time_ok   = !timed || (counter == time_value);
    // input strobe qualifies each transfer when enabled
    wire stb_ok    = !stb_in || strobe_input_qualifier;
    // input waits until the pin condition holds
    wire wait_ok   = dir_out || !cond_en || cond_met;
    wire go        = sel_tick && port_live && time_ok && stb_ok && wait_ok;

    wire [7:0]    last_slot = serial ? 8'(SLOTS - 1) : 8'h00;
    wire [XW-1:0] in_word   = serial ? {pin_in, shift_reg[XW-1:WIDTH]} : XW'(pin_in);
    wire          out_load  = go && dir_out && (slot_cnt == 8'h00) && xfer_full;
    wire          out_shift = go && dir_out && (slot_cnt != 8'h00);
    wire          in_step   = go && !dir_out;
    wire          in_done   = in_step && (slot_cnt == last_slot);

    always_comb
    begin
        next_xfer      = xfer;
        next_xfer_full = xfer_full;
        next_shift_reg = shift_reg;
        next_slot_cnt  = slot_cnt;
        next_drive_val = drive_val;
        next_stamp     = stamp;
        next_strobe    = 1'b0;
        next_event     = 1'b0;
        // Software side first, so a hardware set below wins a same-cycle clear
        if (rd_data && !dir_out)
            next_xfer_full = 1'b0;
        if (out_load)
        begin
            next_drive_val = xfer[WIDTH-1:0];
            next_shift_reg = xfer >> WIDTH;
            next_slot_cnt  = last_slot;
            next_xfer_full = 1'b0;
            next_stamp     = counter;
            next_strobe    = stb_out;
        end
        else if (out_shift)
        begin
            next_drive_val = shift_reg[WIDTH-1:0];
            next_shift_reg = shift_reg >> WIDTH;
            next_slot_cnt  = slot_cnt - 8'h01;
            next_strobe    = stb_out;
        end
        else if (in_step)
        begin
            next_shift_reg = in_word;
            next_slot_cnt  = in_done ? 8'h00 : slot_cnt + 8'h01;
            if (in_done)
            begin
                next_xfer      = in_word;
                next_xfer_full = 1'b1;
                next_stamp     = counter;
                // completed input raises a tile event
                next_event     = 1'b1;
            end
        end
        // Software write to the output holding register; newest word wins
        if (wr_data && dir_out)
        begin
            next_xfer      = wdata;
            next_xfer_full = 1'b1;
        end
    end

    // Pin drive per bit
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_pin
            // a narrower port's claim releases this pin only
            wire owned = port_live && dir_out && !narrower_claim[gi];
            // open collector releases on a one
            wire drive = owned && !(oc_mode && next_drive_val[gi]);
            // direction is the single port-wide bit
            assign next_pin_oe_n[gi] = !drive;
            assign next_pin_out[gi]  = oc_mode ? 1'b0 : next_drive_val[gi];
        end
    endgenerate

    // read data in the next cycle, never stalled
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (rd)
        begin
            case (addr)
                ADDR_W'(hr_port_pkg::OFF_CTRL):    next_rdata = 32'(ctrl);
                ADDR_W'(hr_port_pkg::OFF_DATA):    next_rdata = xfer;
                ADDR_W'(hr_port_pkg::OFF_COND):    next_rdata = 32'(cond_value);
                ADDR_W'(hr_port_pkg::OFF_TIME):    next_rdata = 32'(time_value);
                ADDR_W'(hr_port_pkg::OFF_COUNTER): next_rdata = 32'(counter);
                ADDR_W'(hr_port_pkg::OFF_STAMP):   next_rdata = 32'(stamp);
                ADDR_W'(hr_port_pkg::OFF_STATUS):
                begin
                    next_rdata[hr_port_pkg::ST_OUT_FULL] = xfer_full && dir_out;
                    next_rdata[hr_port_pkg::ST_IN_VALID] = xfer_full && !dir_out;
                    next_rdata[hr_port_pkg::ST_EVENT]    = event_sticky;
                    next_rdata[hr_port_pkg::ST_LINK]     = link_enable;
                    next_rdata[hr_port_pkg::ST_COND_MET] = cond_met;
                end
                default:
                begin
                    if (cb_hit)
                        next_rdata = 32'(cb_cfg[cb_idx]);
                end
            endcase
        end
    end

    // Software registers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            // clock select resets to block 0
            ctrl       <= hr_port_pkg::CTRL_RESET;
            cond_value <= '0;
            time_value <= hr_port_pkg::CNT_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= wdata[hr_port_pkg::CTRL_W-1:0];
            else if (go && timed)
                ctrl[hr_port_pkg::CTRL_TIMED] <= 1'b0;   // One-shot timed transfer
            if (wr_cond)
                cond_value <= wdata[WIDTH-1:0];
            if (wr_time)
                time_value <= wdata[CW-1:0];
        end
    end

    generate
        for (gi = 0; gi < NCB; gi++)
        begin : g_cfg
            always_ff @(posedge clk)
            begin
                if (!reset_n)
                    cb_cfg[gi] <= hr_port_pkg::CB_CFG_RESET;
                else if (wr && cb_hit && cb_idx == 3'(gi))
                    cb_cfg[gi] <= wdata[hr_port_pkg::CB_CFG_W-1:0];
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            counter <= hr_port_pkg::CNT_RESET;
        // one step per selected tick, wraps naturally
        else if (sel_tick)
            counter <= counter + 1'b1;
    end

    // Datapath registers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            xfer      <= '0;
            xfer_full <= 1'b0;
            shift_reg <= '0;
            slot_cnt  <= 8'h00;
            drive_val <= '0;
            stamp     <= hr_port_pkg::CNT_RESET;
        end
        else
        begin
            xfer      <= next_xfer;
            xfer_full <= next_xfer_full;
            shift_reg <= next_shift_reg;
            slot_cnt  <= next_slot_cnt;
            drive_val <= next_drive_val;
            stamp     <= next_stamp;
        end
    end

    // Sticky event flag; a new event wins over the status-read clear
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            event_sticky <= 1'b0;
        else if (next_event)
            event_sticky <= 1'b1;
        else if (rd_stat)
            event_sticky <= 1'b0;
    end

    // Registered outputs; pins released while in reset
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rdata                <= 32'h0000_0000;
            pin_out              <= '0;
            pin_oe_n             <= '1;
            strobe_output_marker <= 1'b0;
            event_pulse          <= 1'b0;
            pulldown_en          <= 1'b1;
        end
        else
        begin
            rdata                <= next_rdata;
            pin_out              <= next_pin_out;
            pin_oe_n             <= next_pin_oe_n;
            strobe_output_marker <= next_strobe;
            event_pulse          <= next_event;
            pulldown_en          <= 1'b0;
        end
    end

    // width is fixed by the parameter whatever the pin claims
    // legal widths are 1, 4, 8, 16 and 32
endmodule

//--- bench/ext_hw.sv
// External hardware model that sits on the port pins
`timescale 1ns/1ps
module ext_hw #(parameter int WIDTH = 4)
(
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] pin_out,
    input  wire logic [WIDTH-1:0] pin_oe_n,
    input  wire logic             strobe_output_marker,
    input  wire logic             drive,
    input  wire logic [WIDTH-1:0] drive_val,
    input  wire logic             stb_req,
    output logic      [WIDTH-1:0] pin_in,
    output logic                  strobe_input_qualifier,
    output logic                  clk_pin_in,
    output int                    stb_seen
);
    // Port drive wins; a released undriven pin sits on its pull-up
    // released undriven pin high
    always_comb
        for (int i = 0; i < WIDTH; i++)
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (drive ? drive_val[i] : 1'b1);

    assign strobe_input_qualifier = stb_req;

    // Count output strobes seen by the far side
    initial stb_seen = 0;
    always @(posedge clk)
        if (strobe_output_marker === 1'b1)
            stb_seen <= stb_seen + 1;

    // Application clock; stands low between bursts, phase unrelated to clk
    initial clk_pin_in = 1'b0;
    task automatic pin_clocks(input int n);
        repeat (n)
        begin
            #35 clk_pin_in = 1'b1;
            #35 clk_pin_in = 1'b0;
        end
    endtask
endmodule

//--- bench/hw_response_port_chk.sv
// Concurrent checks on the port unit's pins and register bus
`timescale 1ns/1ps
module hw_response_port_chk #(
    parameter int WIDTH  = 4,
    parameter int ADDR_W = 8
)
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              rd,
    input wire logic [31:0]       rdata,
    input wire logic [WIDTH-1:0]  pin_oe_n,
    input wire logic              pulldown_en,
    input wire logic              strobe_output_marker,
    input wire logic              link_enable,
    input wire logic [WIDTH-1:0]  narrower_claim,
    input wire logic              event_pulse
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Bus answers only in the cycle after a read
    a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside its answer cycle");
    a_release_state: assert property ($rose(reset_n) |-> pulldown_en && (&pin_oe_n) && !strobe_output_marker)
        else $error("outputs not in reset state at release");
    a_pulldown_off: assert property ($past(reset_n) |-> !pulldown_en)
        else $error("pull-down still on after reset");
    // Link ownership quiets the port
    a_link_release: assert property (link_enable && $past(link_enable) |-> &pin_oe_n)
        else $error("pins driven while link owns them");
    a_link_quiet: assert property ($past(link_enable) && $past(link_enable, 2) |-> !strobe_output_marker && !event_pulse)
        else $error("transfer activity while link owns the pins");
    a_claim_release: assert property ($stable(narrower_claim) |-> (pin_oe_n & narrower_claim) == narrower_claim)
        else $error("claimed pin still driven");
    a_status_link: assert property ($past(rd) && $past(addr) == hr_port_pkg::OFF_STATUS |->
        rdata[3] == $past(link_enable) && rdata[31:5] == 27'h0)
        else $error("status link bit wrong");
    a_counter_width: assert property ($past(rd) && ($past(addr) == hr_port_pkg::OFF_COUNTER ||
        $past(addr) == hr_port_pkg::OFF_STAMP) |-> rdata[31:16] == 16'h0)
        else $error("counter or stamp wider than 16 bits");
endmodule

bind hw_response_port hw_response_port_chk #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) chk (.*);

//--- bench/tb_top.sv
// Self-checking bench for the hardware response port
`timescale 1ns/1ps
module tb_top;
    localparam int         WIDTH = 4;
    localparam logic [7:0] CTRL = hr_port_pkg::OFF_CTRL, DATA = hr_port_pkg::OFF_DATA, COND = hr_port_pkg::OFF_COND,
                           TMR = hr_port_pkg::OFF_TIME, CNT = hr_port_pkg::OFF_COUNTER,
                           STAMP = hr_port_pkg::OFF_STAMP, STAT = hr_port_pkg::OFF_STATUS;
    logic              clk, reset_n, wr, rd, pulldown_en, stb_in, stb_q, stb_out;
    logic              link_enable, clk_pin_in, event_pulse, drive;
    logic [7:0]        addr;
    logic [31:0]       wdata, rdata, v, c0, d;
    logic [WIDTH-1:0]  pin_in, pin_out, pin_oe_n, claim, drive_val;
    int                stb_seen, n;
    int                events      = 0;
    int                miscompares = 0;
    int                compares    = 0;

    hw_response_port #(.WIDTH(WIDTH)) dut (.*, .strobe_input_qualifier(stb_q), .strobe_output_marker(stb_out),
        .narrower_claim(claim));
    ext_hw #(.WIDTH(WIDTH)) partner (.*, .strobe_output_marker(stb_out), .stb_req(stb_in),
        .strobe_input_qualifier(stb_q));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Count tile events
    always @(posedge clk)
        if (event_pulse === 1'b1)
            events <= events + 1;

    function automatic logic [31:0] cnt16(input logic [31:0] x);
        return {16'h0, x[15:0]};
    endfunction

    // Open collector releases the ones
    function automatic logic [31:0] exp_oe(input logic oc, input logic [31:0] x);
        return oc ? {28'h0, x[3:0]} : 32'h0;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] dat);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= dat;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Answer sampled at the edge that ends its cycle
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] dat);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        dat = rdata;
    endtask

    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Run is near 400 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("ERROR watchdog expected done seen hang");
        tally_and_finish();
    end

    initial
    begin
        {reset_n, wr, rd, link_enable, drive, stb_in} = 6'h0;
        {addr, wdata, claim, drive_val} = '0;
        v = $urandom(32'hef2e9533);
        repeat (10) @(posedge clk);
        check("pulldown in reset", 32'h1, {31'h0, pulldown_en});
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd_reg(CTRL, v);
        check("ctrl after reset", 32'h0, v);
        check("pins released", 32'hf, {28'h0, pin_oe_n});
        rd_reg(CNT, c0);
        rd_reg(CNT, v);
        check("counter step", cnt16(c0 + 3), v);
        $display("test reset done");
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(CTRL, k[0] ? 32'h87 : 32'h83);
            n = stb_seen;
            d = 32'($urandom_range(15, 0));
            wr_reg(DATA, d);
            rd_reg(CNT, c0);
            rd_reg(STAMP, v);
            check("stamp", cnt16(c0 - 1), v);
            check("pin level", d, {28'h0, pin_in});
            check("pin enable", exp_oe(k[0], d), {28'h0, pin_oe_n});
            check("strobe count", n + 1, stb_seen);
        end
        repeat (6) @(posedge clk);
        check("pins hold", d, {28'h0, pin_in});
        wr_reg(CTRL, 32'h83);
        wr_reg(DATA, 32'hc);
        claim <= 4'h3;
        repeat (4) @(posedge clk);
        check("claimed pins", 32'h3, {28'h0, pin_oe_n});
        check("unclaimed pins", 32'h3, {30'h0, pin_in[3:2]});
        link_enable <= 1'b1;
        rd_reg(STAT, v);
        check("link status", 32'h1, {31'h0, v[3]});
        link_enable <= 1'b0;
        claim <= 4'h0;
        rd_reg(CNT, c0);
        wr_reg(TMR, cnt16(c0 + 40));
        wr_reg(CTRL, 32'h8b);
        wr_reg(DATA, 32'h3);
        repeat (5) @(posedge clk);
        check("timed waits", 32'hc, {28'h0, pin_out});
        repeat (40) @(posedge clk);
        check("timed fires", 32'h3, {28'h0, pin_out});
        rd_reg(STAMP, v);
        check("timed stamp", cnt16(c0 + 40), v);
        wr_reg(CTRL, 32'h883);
        n = stb_seen;
        d = $urandom();
        wr_reg(DATA, d);
        repeat (12) @(posedge clk);
        check("serial strobes", n + 8, stb_seen);
        check("serial last slot", {28'h0, d[31:28]}, {28'h0, pin_in});
        $display("test output done");
        drive <= 1'b1;
        drive_val <= 4'($urandom_range(15, 0));
        wr_reg(CTRL, 32'h1);
        n = events;
        repeat (3) @(posedge clk);
        rd_reg(DATA, v);
        check("input word", {28'h0, drive_val}, v);
        check("input released", 32'hf, {28'h0, pin_oe_n});
        check("event pulses", 32'h1, {31'h0, events > n});
        rd_reg(STAT, v);
        check("event sticky", 32'h1, {31'h0, v[2]});
        for (int k = 0; k < 2; k++)
        begin
            drive_val <= k[0] ? 4'ha : 4'h3;
            wr_reg(COND, 32'ha);
            wr_reg(CTRL, k[0] ? 32'h31 : 32'h11);
            rd_reg(DATA, v);
            repeat (4) @(posedge clk);
            rd_reg(STAT, v);
            check("cond holds off", 32'h0, {30'h0, v[4], v[1]});
            d = k[0] ? 32'h5 : 32'ha;
            drive_val <= d[3:0];
            repeat (3) @(posedge clk);
            rd_reg(DATA, v);
            check("cond met word", d, v);
        end
        wr_reg(CTRL, 32'h41);
        drive_val <= 4'h6;
        rd_reg(DATA, v);
        rd_reg(STAT, v);
        check("strobe holds off", 32'h0, {31'h0, v[1]});
        stb_in <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(DATA, v);
        check("strobed word", 32'h6, v);
        stb_in <= 1'b0;
        $display("test input done");
        for (int i = 1; i < 6; i++)
        begin
            wr_reg(8'(hr_port_pkg::OFF_CB_BASE + 4 * i), 32'(32'h100 + i - 1));
            wr_reg(CTRL, 32'(1 + (i << 8)));
            rd_reg(CNT, c0);
            partner.pin_clocks(2 * i);
            repeat (4) @(posedge clk);
            rd_reg(CNT, v);
            check("pin clock ticks", cnt16(c0 + 2), v);
        end
        wr_reg(CTRL, 32'h701);
        rd_reg(CNT, c0);
        rd_reg(CNT, v);
        check("select above five", cnt16(c0 + 3), v);
        wr_reg(8'h3c, $urandom());
        rd_reg(8'h3c, v);
        check("unmapped read", 32'h0, v);
        $display("test clocks done");
        tally_and_finish();
    end
endmodule
